// >>> bench/axis_encoder_position_regulator_tb.sv
/*
  Self-checking bench: registers over AXI4-Lite, counting, index latch, regulator.
  Assumes ready outputs settle from registers updated by non-blocking assignment.
*/
`timescale 1ns/1ps
module axis_encoder_position_regulator_tb;
  import axis_enc_pkg::*;
  logic        aclk = 1'h0, aresetn = 1'h0, awv = 1'h0, wv = 1'h0, bready = 1'h0;
  logic        arv = 1'h0, rready = 1'h0, step = 1'h0, dir = 1'h0, idx_n = 1'h0;
  logic        quiescent = 1'h0, awr, wr_rdy, bvalid, arr, rvalid, active, lr;
  logic [3:0]  strb = 4'hF;
  logic [1:0]  cmp = 2'h0;
  logic [9:0]  awaddr = '0, araddr = '0;
  logic [31:0] wdata = '0, rdata, ramp_status_word = '0, target_position = '0, cnt = '0, v;
  logic [1:0]  bresp, rresp;
  logic [7:0]  hyst;
  logic [7:0]  hv [8] = '{8'h0A, 8'h19, 8'h32, 8'h4B, 8'h64, 8'h96, 8'hC8, 8'hFA};
  enc_pins_s   pins;
  reg_out_s    ro;
  int          bad_count = 0, n_checks = 0, cyc = 0, lr_n = 0;

  axis_encoder_position_regulator #(.DIV0(4), .DIV1(3), .DIV2(2), .BUNIT(3))
    axis_encoder_position_regulator_inst (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wdata),
    .s_axi_wstrb(strb), .s_axi_wvalid(wv), .s_axi_wready(wr_rdy), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .enc_pins(pins), .bemf_cmp(cmp),
    .quiescent(quiescent), .ramp_status_word(ramp_status_word),
    .target_position(target_position), .reg_out_ff(ro), .bemf_hyst_mv_ff(hyst),
    .decoder_active(active), .latch_ramp_ff(lr));
  quad_encoder_model quad_encoder_model_inst (.aclk(aclk), .step(step), .dir(dir),
    .index(idx_n), .pins(pins));

  // ====================
  initial begin
    forever #2.5 aclk = ~aclk;
  end
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (lr) lr_n <= lr_n + 1;
    if (cyc == 8000) begin
      bad_count++;
      summarize();
    end
  end

  // ====================
  task automatic chk(input logic [45:0] got, input logic [45:0] exp);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] idx, input logic [31:0] d, input logic [1:0] er);
    awaddr <= {idx, 2'h0};
    wdata <= d;
    awv <= 1'h1;
    wv <= 1'h1;
    bready <= 1'h1;
    do begin
      @(posedge aclk);
      if (awr) awv <= 1'h0;
      if (wr_rdy) wv <= 1'h0;
    end while (!bvalid);
    chk(bresp, er);
    bready <= 1'h0;
    @(posedge aclk);
  endtask
  task automatic rchk(input logic [7:0] idx, input logic [31:0] exp, input logic [1:0] er);
    araddr <= {idx, 2'h0};
    arv <= 1'h1;
    rready <= 1'h1;
    do begin
      @(posedge aclk);
      if (arr) arv <= 1'h0;
    end while (!rvalid);
    chk({rresp, rdata}, {er, exp});
    rready <= 1'h0;
    @(posedge aclk);
  endtask
  task automatic mv(input int n, input logic d, input logic on);
    repeat (n) begin
      step <= 1'h1;
      dir <= d;
      @(posedge aclk);
      step <= 1'h0;
      @(posedge aclk);
    end
    if (on) cnt = d ? cnt + n : cnt - n;
    repeat (2) @(posedge aclk);
  endtask
  function automatic reg_out_s want_reg(logic [31:0] ctl);
    longint e;
    logic   db;
    e = longint'($signed(target_position)) - longint'($signed(cnt));
    db = ((e < 0 ? -e : e) < ctl[23:16]) && (!ctl[28] || ramp_status_word[9]);
    return '{ctl[9:0] != 0, db, (ctl[9:0] != 0 && !db) ? 44'(ctl[9:0] * e) : 44'h0};
  endfunction
  task automatic summarize();
    if (bad_count == 0 && n_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // ====================
  initial begin
    void'($urandom(32'h24C874FE));
    repeat (4) @(posedge aclk);
    aresetn <= 1'h1;
    @(posedge aclk);
    chk(hyst, 8'h0A);
    rchk(IDX_POS_CTRL, 32'h1000_0000, RESP_OKAY);
    rchk(IDX_ENC_COUNT, 32'h0, RESP_OKAY);
    rchk(IDX_ENC_MODE, 32'h0010_8000, RESP_OKAY);
    rchk(8'h10, 32'h0, RESP_SLVERR);
    wr(IDX_ENC_LATCH, 32'h1, RESP_SLVERR);
    mv(4, 1'h1, 1'h0);
    rchk(IDX_ENC_COUNT, 32'h0, RESP_OKAY);
    for (int c = 0; c < 8; c++) begin
      v = 32'h0010_8800 | (c << 12) | ((c % 4) << 28);
      wr(IDX_ENC_MODE, v, RESP_OKAY);
      @(posedge aclk);
      chk(hyst, hv[c]);
      rchk(IDX_ENC_MODE, v, RESP_OKAY);
    end
    cnt = 32'h7FFF_FFFD;
    wr(IDX_ENC_COUNT, cnt, RESP_OKAY);
    for (int k = 0; k < 6; k++) begin
      mv($urandom % 9, k[0], 1'h1);
      rchk(IDX_ENC_COUNT, cnt, RESP_OKAY);
    end
    quiescent <= 1'h1;
    mv(4, 1'h1, 1'h1);
    chk(active, 1'h1);
    wr(IDX_ENC_MODE, 32'h0010_0800, RESP_OKAY);
    mv(4, 1'h1, 1'h0);
    chk(active, 1'h0);
    rchk(IDX_ENC_COUNT, cnt, RESP_OKAY);
    quiescent <= 1'h0;
    for (int i = 0; i < 40; i++) begin
      v = {3'h0, 1'($urandom), 4'h0, 8'($urandom), 6'h0, (i % 5 == 0) ? 10'h0 : 10'($urandom)};
      target_position <= (i < 3) ? cnt + v[23:16] - i : cnt + ($urandom % 600) - 300;
      ramp_status_word <= $urandom;
      wr(IDX_POS_CTRL, v, RESP_OKAY);
      repeat (3) @(posedge aclk);
      chk(ro, want_reg(v));
      rchk(IDX_POS_CTRL, v, RESP_OKAY);
    end
    for (int e = 0; e < 4; e++) begin
      v = $urandom;
      wr(IDX_ENC_COUNT, v, RESP_OKAY);
      wr(IDX_ENC_MODE, 32'h0010_8A1C | (e << 6) | (e[0] << 8), RESP_OKAY);
      idx_n <= 1'h1;
      repeat (3) @(posedge aclk);
      idx_n <= 1'h0;
      repeat (3) @(posedge aclk);
      rchk(IDX_ENC_LATCH, (e == 3) ? 32'h0 : v, RESP_OKAY);
      rchk(IDX_ENC_COUNT, e[0] ? 32'h0 : v, RESP_OKAY);
      chk(lr_n, e + 3 + (e == 3));
    end
    strb <= 4'h6;
    wr(IDX_ENC_COUNT, 32'hA5A5_A5A5, RESP_OKAY);
    rchk(IDX_ENC_COUNT, 32'h00A5_A500, RESP_OKAY);
    strb <= 4'hF;
    // back-EMF pair as count source: filter delay, then blanking holds off the next change
    wr(IDX_ENC_MODE, ENC_MODE_RESET, RESP_OKAY);
    wr(IDX_ENC_COUNT, 32'h0, RESP_OKAY);
    cmp <= 2'h1;
    repeat (3) @(posedge aclk);
    rchk(IDX_ENC_COUNT, 32'h0, RESP_OKAY);
    cmp <= 2'h3;
    repeat (20) @(posedge aclk);
    rchk(IDX_ENC_COUNT, 32'h1, RESP_OKAY);
    repeat (60) @(posedge aclk);
    rchk(IDX_ENC_COUNT, 32'h2, RESP_OKAY);
    summarize();
  end
endmodule // axis_encoder_position_regulator_tb

// >>> bench/quad_encoder_model.sv
/*
  Quadrature encoder model: gray-code A/B steps on request, index level on N.
  Assumes requests change just after a rising aclk edge.
*/
`timescale 1ns/1ps
module quad_encoder_model (
  input  wire logic               aclk,  // system clock
  input  wire logic               step,  // move one position
  input  wire logic               dir,   // 1 forward
  input  wire logic               index, // index mark
  output axis_enc_pkg::enc_pins_s pins   // a, b, n
);
  // ====================
  // one pin per step, so the decoder never sees a double change
  logic [1:0] ph = 2'h0;
  always @(posedge aclk) begin
    if (step) ph <= dir ? {ph[0], ~ph[1]} : {~ph[0], ph[1]};
  end
  assign pins = '{a: ph[1], b: ph[0], n: index};
endmodule // quad_encoder_model

// >>> inc/axis_enc_pkg.sv
/*
  Shared constants and carriers for one axis's encoder counter and position regulator:
  register indices, field layouts, reset values, write masks and back-EMF front-end counts.
  Assumes a 32-bit AXI4-Lite register bus with one aligned word per register.
*/
package axis_enc_pkg;

  // ==========================================================================
  // register indices (byte address = 4 x index)
  localparam logic [7:0] IDX_POS_CTRL   = 8'h2D;
  localparam logic [7:0] IDX_ENC_COUNT  = 8'h2E;
  localparam logic [7:0] IDX_ENC_MODE   = 8'h2F;
  localparam logic [7:0] IDX_ENC_LATCH  = 8'h3E;
  localparam logic [7:0] IDX_AXIS_STAT  = 8'h3F;

  // ==========================================================================
  // reset values and writable bits
  localparam logic [31:0] POS_CTRL_RESET  = 32'h1000_0000;
  localparam logic [31:0] POS_CTRL_WMASK  = 32'h10FF_03FF;
  localparam logic [31:0] ENC_COUNT_RESET = 32'h0000_0000;
  localparam logic [31:0] ENC_MODE_RESET  = 32'h0010_8000;
  localparam logic [31:0] ENC_MODE_WMASK  = 32'h30FF_FFFF;
  localparam logic [31:0] ALL_BITS        = 32'hFFFF_FFFF;
  localparam int unsigned CLR_ONCE_BIT    = 5;
  localparam int unsigned POS_REACHED_BIT = 9;

  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;

  // ==========================================================================
  // back-EMF front end: filter divisors per select code, blanking unit
  localparam int unsigned FILT_DIV_0 = 24600;
  localparam int unsigned FILT_DIV_1 = 12300;
  localparam int unsigned FILT_DIV_2 = 6150;
  localparam int unsigned FILT_DIV_3 = 2870;
  localparam int unsigned BLANK_UNIT = (1 << 14) - 1;

  // comparator hysteresis in mV, indexed by select code
  localparam logic [7:0][7:0] HYST_MV_TABLE = {8'hFA, 8'hC8, 8'h96, 8'h64,
                                               8'h4B, 8'h32, 8'h19, 8'h0A};

  // ==========================================================================
  // carriers
  typedef struct packed {
    logic [2:0] rsv_hi;
    logic       tol_after_arrival;
    logic [3:0] rsv_mid;
    logic [7:0] tolerance;
    logic [5:0] rsv_lo;
    logic [9:0] gain;
  } pos_ctrl_s;

  typedef struct packed {
    logic [1:0] rsv_top;
    logic [1:0] filt_sel;
    logic [3:0] rsv_hi;
    logic [7:0] blank_time;
    logic       quiescent_keep;
    logic [2:0] hyst_sel;
    logic       source_select;
    logic       decimal_mode;
    logic       latch_ramp_pos;
    logic       clr_on_index;
    logic [1:0] index_edge;
    logic       clr_once;
    logic       clr_cont;
    logic       ignore_ab;
    logic       pol_n;
    logic       pol_b;
    logic       pol_a;
  } enc_mode_s;

  typedef struct packed {
    logic a;
    logic b;
    logic n;
  } enc_pins_s;

  typedef struct packed {
    logic               enable;
    logic               dead_band;
    logic signed [43:0] correction;
  } reg_out_s;

endpackage

// >>> logic/axis_encoder_position_regulator.sv
/*
  One axis's encoder counter, index latch and proportional position regulator, with
  the back-EMF decoder setup, reached over an AXI4-Lite slave.
  Assumes encoder pins, comparators and ramp-generator signals are synchronous to aclk.
*/
`timescale 1ns/1ps
module axis_encoder_position_regulator #(
  parameter int unsigned ADDR_W = 10,                       // AXI address width
  parameter int unsigned DIV0   = axis_enc_pkg::FILT_DIV_0, // lowpass divisor, code 0
  parameter int unsigned DIV1   = axis_enc_pkg::FILT_DIV_1, // lowpass divisor, code 1
  parameter int unsigned DIV2   = axis_enc_pkg::FILT_DIV_2, // lowpass divisor, code 2
  parameter int unsigned BUNIT  = axis_enc_pkg::BLANK_UNIT  // blanking step in clocks
) (
  input  wire logic               aclk,             // system clock, 200 MHz
  input  wire logic               aresetn,          // sync reset, active low
  input  wire logic [ADDR_W-1:0]  s_axi_awaddr,     // write address
  input  wire logic               s_axi_awvalid,    // write address valid
  output logic                    s_axi_awready,    // write address ready
  input  wire logic [31:0]        s_axi_wdata,      // write data
  input  wire logic [3:0]         s_axi_wstrb,      // byte enables
  input  wire logic               s_axi_wvalid,     // write data valid
  output logic                    s_axi_wready,     // write data ready
  output logic [1:0]              s_axi_bresp,      // write response
  output logic                    s_axi_bvalid,     // write response valid
  input  wire logic               s_axi_bready,     // write response ready
  input  wire logic [ADDR_W-1:0]  s_axi_araddr,     // read address
  input  wire logic               s_axi_arvalid,    // read address valid
  output logic                    s_axi_arready,    // read address ready
  output logic [31:0]             s_axi_rdata,      // read data
  output logic [1:0]              s_axi_rresp,      // read response
  output logic                    s_axi_rvalid,     // read data valid
  input  wire logic               s_axi_rready,     // read data ready
  input  wire axis_enc_pkg::enc_pins_s enc_pins,    // incremental A, B, N
  input  wire logic [1:0]         bemf_cmp,         // back-EMF comparator pair
  input  wire logic               quiescent,        // motor in quiescence
  input  wire logic [31:0]        ramp_status_word, // motion controller status
  input  wire logic [31:0]        target_position,  // regulator set point
  output axis_enc_pkg::reg_out_s  reg_out_ff,       // regulator result
  output logic [7:0]              bemf_hyst_mv_ff,  // comparator hysteresis, mV
  output logic                    decoder_active,   // decoders running
  output logic                    latch_ramp_ff     // pulse: latch ramp position
);
  import axis_enc_pkg::*;

  if (ADDR_W < 10 || DIV0 == 0 || DIV1 == 0 || DIV2 == 0 || BUNIT == 0) begin : g_chk
    $error("axis_encoder_position_regulator: unsupported parameters");
  end

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] data,
                                        input logic [3:0] strb, input logic [31:0] mask);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) res[i*8 +: 8] = data[i*8 +: 8];
    end
    return res & mask;
  endfunction

  // ==========================================================================
  // AXI4-Lite write path
  pos_ctrl_s   ctrl_ff;
  enc_mode_s   mode_ff;
  logic [31:0] count_ff;
  logic [31:0] latch_ff;
  logic        once_armed_ff;
  logic [7:0]  aw_idx_ff;
  logic        aw_full_ff;
  logic [31:0] w_data_ff;
  logic [3:0]  w_strb_ff;
  logic        w_full_ff;
  logic        wr_fire;
  logic        wr_ok;

  assign s_axi_awready = !aw_full_ff && !s_axi_bvalid;
  assign s_axi_wready  = !w_full_ff && !s_axi_bvalid;
  assign wr_fire       = aw_full_ff && w_full_ff && !s_axi_bvalid;
  assign wr_ok         = (aw_idx_ff == IDX_POS_CTRL) || (aw_idx_ff == IDX_ENC_COUNT)
                      || (aw_idx_ff == IDX_ENC_MODE);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_ff <= 1'b0;
      aw_idx_ff  <= 8'h00;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_full_ff <= 1'b1;
      aw_idx_ff  <= s_axi_awaddr[9:2];
    end else if (wr_fire) begin
      aw_full_ff <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_full_ff <= 1'b0;
      w_data_ff <= 32'h0000_0000;
      w_strb_ff <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_full_ff <= 1'b1;
      w_data_ff <= s_axi_wdata;
      w_strb_ff <= s_axi_wstrb;
    end else if (wr_fire) begin
      w_full_ff <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wr_ok ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_ff <= POS_CTRL_RESET;
      mode_ff <= ENC_MODE_RESET;
    end else if (wr_fire && aw_idx_ff == IDX_POS_CTRL) begin
      ctrl_ff <= merge(ctrl_ff, w_data_ff, w_strb_ff, POS_CTRL_WMASK);
    end else if (wr_fire && aw_idx_ff == IDX_ENC_MODE) begin
      mode_ff <= merge(mode_ff, w_data_ff, w_strb_ff, ENC_MODE_WMASK);
    end
  end

  // ==========================================================================
  // decoders and index event
  logic       dec_on;
  logic [1:0] bemf_filt;
  logic       blanking;
  logic [1:0] ab_cur;
  logic [1:0] ab_prev_ff;
  logic       step;
  logic       step_up;
  logic       n_active;
  logic       n_prev_ff;
  logic       index_evt;
  logic       index_fire;
  logic       sw_count_wr;
  logic       sw_once_wr;

  assign dec_on         = mode_ff.quiescent_keep || !quiescent;
  assign decoder_active = dec_on;

  bemf_front_end #(
    .DIV0  (DIV0),
    .DIV1  (DIV1),
    .DIV2  (DIV2),
    .DIV3  (FILT_DIV_3),
    .BUNIT (BUNIT)
  ) u_bemf (
    .aclk       (aclk),
    .aresetn    (aresetn),
    .run        (dec_on),
    .cmp        (bemf_cmp),
    .filt_sel   (mode_ff.filt_sel),
    .blank_time (mode_ff.blank_time),
    .filt_ff    (bemf_filt),
    .blanking   (blanking)
  );

  assign ab_cur  = mode_ff.source_select ? {enc_pins.a, enc_pins.b} : bemf_filt;
  // a double change is a lost step and is dropped rather than guessed
  assign step    = dec_on && (ab_cur != ab_prev_ff) && ((ab_cur ^ ab_prev_ff) != 2'h3);
  assign step_up = ab_prev_ff[1] ^ ab_cur[0];

  assign n_active = (enc_pins.n == mode_ff.pol_n)
                 && (mode_ff.ignore_ab || (enc_pins.a == mode_ff.pol_a
                                           && enc_pins.b == mode_ff.pol_b));

  always_comb begin
    unique case (mode_ff.index_edge)
      2'h0: index_evt = n_active;
      2'h1: index_evt = n_active && !n_prev_ff;
      2'h2: index_evt = !n_active && n_prev_ff;
      2'h3: index_evt = n_active != n_prev_ff;
    endcase
  end

  assign index_fire  = dec_on && index_evt && (mode_ff.clr_cont || once_armed_ff);
  assign sw_count_wr = wr_fire && aw_idx_ff == IDX_ENC_COUNT;
  assign sw_once_wr  = wr_fire && aw_idx_ff == IDX_ENC_MODE && w_strb_ff[0]
                    && w_data_ff[CLR_ONCE_BIT];

  // prev sampled even while gated, so re-enabling does not invent a step
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ab_prev_ff <= 2'h0;
      n_prev_ff  <= 1'b0;
    end else begin
      ab_prev_ff <= ab_cur;
      n_prev_ff  <= n_active;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      once_armed_ff <= 1'b0;
    end else if (sw_once_wr) begin
      once_armed_ff <= 1'b1;
    end else if (index_fire) begin
      once_armed_ff <= 1'b0;
    end
  end

  // software overwrite wins over an index clear or a step in the same cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      count_ff <= ENC_COUNT_RESET;
    end else if (sw_count_wr) begin
      count_ff <= merge(count_ff, w_data_ff, w_strb_ff, ALL_BITS);
    end else if (index_fire && mode_ff.clr_on_index) begin
      count_ff <= 32'h0000_0000;
    end else if (step) begin
      count_ff <= step_up ? count_ff + 32'h1 : count_ff - 32'h1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      latch_ff      <= 32'h0000_0000;
      latch_ramp_ff <= 1'b0;
    end else begin
      latch_ramp_ff <= index_fire && mode_ff.latch_ramp_pos;
      if (index_fire) latch_ff <= count_ff;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bemf_hyst_mv_ff <= HYST_MV_TABLE[0];
    end else begin
      bemf_hyst_mv_ff <= HYST_MV_TABLE[mode_ff.hyst_sel];
    end
  end

  // ==========================================================================
  // proportional regulator
  logic signed [32:0] err;
  logic        [32:0] abs_err;
  logic               band_on;
  logic               in_band;

  assign err     = $signed({target_position[31], target_position})
                 - $signed({count_ff[31], count_ff});
  assign abs_err = err[32] ? 33'(-err) : 33'(err);
  assign band_on = ctrl_ff.tol_after_arrival ? ramp_status_word[POS_REACHED_BIT]
                                             : 1'b1;
  assign in_band = band_on && (abs_err < {25'h0, ctrl_ff.tolerance});

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      reg_out_ff <= '0;
    end else begin
      reg_out_ff.enable    <= ctrl_ff.gain != 10'h000;
      reg_out_ff.dead_band <= in_band;
      if (ctrl_ff.gain == 10'h000 || in_band) begin
        reg_out_ff.correction <= 44'sh0;
      end else begin
        // product formed at full width: a wrapped set point gives errors near 2^32
        reg_out_ff.correction <= 44'($signed({1'b0, ctrl_ff.gain}) * 44'(err));
      end
    end
  end

  // ==========================================================================
  // AXI4-Lite read path
  logic [31:0] rd_mux;
  logic        rd_ok;
  logic [7:0]  ar_idx;

  assign s_axi_arready = !s_axi_rvalid;
  assign ar_idx        = s_axi_araddr[9:2];

  always_comb begin
    rd_ok  = 1'b1;
    unique case (ar_idx)
      IDX_POS_CTRL:  rd_mux = ctrl_ff;
      IDX_ENC_COUNT: rd_mux = count_ff;
      IDX_ENC_MODE:  rd_mux = mode_ff;
      IDX_ENC_LATCH: rd_mux = latch_ff;
      IDX_AXIS_STAT: rd_mux = {27'h0, once_armed_ff, blanking, reg_out_ff.dead_band,
                               reg_out_ff.enable, dec_on};
      default: begin
        rd_mux = 32'h0000_0000;
        rd_ok  = 1'b0;
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_mux;
      s_axi_rresp  <= rd_ok ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ==========================================================================
  // checks
  chk_gain_zero_off: assert property (@(posedge aclk) disable iff (!aresetn)
    (ctrl_ff.gain == 10'h000) |=> (!reg_out_ff.enable && reg_out_ff.correction == 44'sh0))
    else $error("regulator active with zero gain");

  chk_band_always: assert property (@(posedge aclk) disable iff (!aresetn)
    (!ctrl_ff.tol_after_arrival && abs_err < {25'h0, ctrl_ff.tolerance})
    |=> (reg_out_ff.dead_band && reg_out_ff.correction == 44'sh0))
    else $error("small error not ignored with tolerance always on");

  chk_band_arrival: assert property (@(posedge aclk) disable iff (!aresetn)
    (ctrl_ff.tol_after_arrival && !ramp_status_word[POS_REACHED_BIT]
     && ctrl_ff.gain != 10'h000 && err != 33'sh0) |=> (reg_out_ff.correction != 44'sh0))
    else $error("dead band applied before target arrival");

  chk_tol_edge: assert property (@(posedge aclk) disable iff (!aresetn)
    (abs_err >= {25'h0, ctrl_ff.tolerance} && ctrl_ff.gain != 10'h000 && err != 33'sh0)
    |=> !reg_out_ff.dead_band)
    else $error("error at or above tolerance was ignored");

  chk_count_write: assert property (@(posedge aclk) disable iff (!aresetn)
    (sw_count_wr && w_strb_ff == 4'hF) |=> (count_ff == $past(w_data_ff)))
    else $error("encoder count not overwritten by software");

  chk_quiet_hold: assert property (@(posedge aclk) disable iff (!aresetn)
    (!mode_ff.quiescent_keep && quiescent && !sw_count_wr) |=> $stable(count_ff))
    else $error("count moved while decoders gated in quiescence");

  chk_index_clear: assert property (@(posedge aclk) disable iff (!aresetn)
    (index_fire && mode_ff.clr_on_index && !sw_count_wr)
    |=> (count_ff == 32'h0000_0000 && latch_ff == $past(count_ff)))
    else $error("index event did not latch and clear the count");

  chk_index_keep: assert property (@(posedge aclk) disable iff (!aresetn)
    (index_fire && !mode_ff.clr_on_index && !sw_count_wr && !step)
    |=> (count_ff == $past(count_ff) && latch_ff == $past(count_ff)))
    else $error("latch-only index event disturbed the count");

  chk_hyst_map: assert property (@(posedge aclk) disable iff (!aresetn)
    ##1 (bemf_hyst_mv_ff == HYST_MV_TABLE[$past(mode_ff.hyst_sel)]))
    else $error("hysteresis output does not follow select code");

endmodule // axis_encoder_position_regulator

// >>> logic/bemf_front_end.sv
/*
  Back-EMF comparator front end: digital lowpass (stability filter) and blanking timer.
  Assumes comparator levels are synchronous to aclk and run is low during gated quiescence.
*/
`timescale 1ns/1ps
module bemf_front_end #(
  parameter int unsigned DIV0  = axis_enc_pkg::FILT_DIV_0, // cutoff divisor, code 0
  parameter int unsigned DIV1  = axis_enc_pkg::FILT_DIV_1, // cutoff divisor, code 1
  parameter int unsigned DIV2  = axis_enc_pkg::FILT_DIV_2, // cutoff divisor, code 2
  parameter int unsigned DIV3  = axis_enc_pkg::FILT_DIV_3, // cutoff divisor, code 3
  parameter int unsigned BUNIT = axis_enc_pkg::BLANK_UNIT  // cycles per blanking step
) (
  input  wire logic       aclk,       // system clock
  input  wire logic       aresetn,    // sync reset, active low
  input  wire logic       run,        // decoder allowed to run
  input  wire logic [1:0] cmp,        // raw comparator pair
  input  wire logic [1:0] filt_sel,   // lowpass select
  input  wire logic [7:0] blank_time, // blanking setting
  output logic      [1:0] filt_ff,    // filtered comparator pair
  output logic            blanking    // blanking window open
);
  import axis_enc_pkg::*;

  if (DIV0 == 0 || DIV1 == 0 || DIV2 == 0 || DIV3 == 0 || BUNIT == 0) begin : g_chk
    $error("bemf_front_end: divisors must be nonzero");
  end

  typedef enum logic [1:0] {ST_TRACK = 2'b00, ST_BLANK = 2'b01} fe_state_e;

  // ==========================================================================
  // filter and blanking
  fe_state_e   state_ff;
  logic [31:0] cnt_ff;
  logic [31:0] div_sel;
  logic [31:0] blank_total;

  always_comb begin
    unique case (filt_sel)
      2'h0: div_sel = DIV0;
      2'h1: div_sel = DIV1;
      2'h2: div_sel = DIV2;
      2'h3: div_sel = DIV3;
    endcase
  end

  assign blank_total = 32'(blank_time) * 32'(BUNIT);
  assign blanking    = (state_ff == ST_BLANK);

  // a change is accepted only after the input differs from filt_ff for a full divisor, which sets the cutoff
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_ff <= ST_TRACK;
      cnt_ff   <= 32'h0000_0000;
      filt_ff  <= 2'h0;
    end else if (!run) begin
      cnt_ff   <= 32'h0000_0000;
    end else begin
      unique case (state_ff)
        ST_TRACK: begin
          if (cmp == filt_ff) begin
            cnt_ff <= 32'h0000_0000;
          end else if (cnt_ff + 32'h1 >= div_sel) begin
            filt_ff <= cmp;
            if (blank_time != 8'h00) begin
              state_ff <= ST_BLANK;
              cnt_ff   <= blank_total;
            end else begin
              cnt_ff   <= 32'h0000_0000;
            end
          end else begin
            cnt_ff <= cnt_ff + 32'h1;
          end
        end
        ST_BLANK: begin
          if (cnt_ff <= 32'h1) begin
            state_ff <= ST_TRACK;
            cnt_ff   <= 32'h0000_0000;
          end else begin
            cnt_ff <= cnt_ff - 32'h1;
          end
        end
      endcase
    end
  end

  // ==========================================================================
  // checks
  chk_blank_start: assert property (@(posedge aclk) disable iff (!aresetn)
    (run && state_ff == ST_TRACK && cmp != filt_ff && cnt_ff + 32'h1 >= div_sel
     && blank_time != 8'h00) |=> (blanking && cnt_ff == $past(blank_total)))
    else $error("blanking did not start with the programmed length");

  chk_filter_hold: assert property (@(posedge aclk) disable iff (!aresetn)
    (filt_ff != $past(filt_ff)) |-> ($past(cnt_ff) + 32'h1 >= $past(div_sel)))
    else $error("filtered level changed before the divisor elapsed");

endmodule // bemf_front_end
